/* File: src/fsw_pkg.sv */
package fsw_pkg;
  // Register offsets, bytes on the Avalon-MM slave
  localparam logic [3:0] FSW_REG_CTRL = 4'h0;
  localparam logic [3:0] FSW_REG_ADDR = 4'h4;
  localparam logic [3:0] FSW_REG_DATA = 4'h8;
  localparam logic [3:0] FSW_REG_STAT = 4'hC;
  // Command field codes in the control register
  localparam logic [2:0] FSW_CMD_READ = 3'h1;
  localparam logic [2:0] FSW_CMD_WRITE = 3'h2;
  localparam logic [2:0] FSW_CMD_CHIP_ERASE = 3'h3;
  localparam logic [2:0] FSW_CMD_POLL = 3'h4;
  localparam logic [2:0] FSW_CMD_RESET = 3'h5;
  // Status bit positions
  localparam int FSW_ST_BUSY = 0;
  localparam int FSW_ST_DONE = 1;
  localparam int FSW_ST_PASS = 2;
  localparam int FSW_ST_FAIL = 3;
  localparam int FSW_ST_DATA_LSB = 8;
  // Unlock and command bytes
  localparam logic [18:0] FSW_UNLOCK_A1 = 19'h05555;
  localparam logic [18:0] FSW_UNLOCK_A2 = 19'h02AAA;
  localparam logic [7:0] FSW_UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] FSW_UNLOCK_D2 = 8'h55;
  localparam logic [7:0] FSW_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FSW_CHIP_ERASE = 8'h10;
  localparam logic [7:0] FSW_RESET_CMD = 8'hF0;
  // Flag bit positions on the data bus
  localparam int FSW_POLLING_FLAG = 7;
  localparam int FSW_MAIN_TOGGLE_FLAG = 6;
  localparam int FSW_TIMEOUT_FLAG = 5;
  localparam int FSW_ERASE_REGION_TOGGLE = 2;
  // Bus timing, ns, at 50 ns clock
  localparam int FSW_CLK_NS = 50;
  localparam int FSW_ACCESS_NS = 150;
  localparam int FSW_WP_NS = 50;
  localparam int FSW_ACCESS_CYC = (FSW_ACCESS_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  localparam int FSW_WP_CYC = (FSW_WP_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  localparam logic [3:0] FSW_ACCESS_CNT = FSW_ACCESS_CYC[3:0];
  localparam logic [3:0] FSW_WP_CNT = FSW_WP_CYC[3:0];
  // Reset values
  localparam logic [31:0] FSW_ZERO_RST = 32'h00000000;
  typedef enum logic [3:0] {
    FSW_IDLE, FSW_W_SETUP, FSW_W_PULSE, FSW_W_HOLD,
    FSW_R_SETUP, FSW_R_WAIT, FSW_R_HOLD, FSW_DECIDE
  } fsw_state_t;
endpackage

/* File: src/fsw_host.sv */
// What this block does
// - Use both toggles to tell completion
// - Read toggles twice, compare, then timeout
// - Timeout high: recheck; still toggling means reset
// - Timeout low: keep polling toggles and timeout
// - Reread erase region toggle after timeout seen
// - Reread main toggle after timeout seen
// - Write only with select, write low, output high
// - Chip erase: six writes, AA 55 ... 10
`timescale 1ns/1ps
`default_nettype none
module fsw_host
  import fsw_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [18:0] flash_addr_out,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);
  fsw_state_t state_q;
  logic [18:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] prev_q;
  logic [7:0] dq_meta_q;
  logic [7:0] dq_sync_q;
  logic [3:0] cnt_q;
  logic [2:0] step_q;
  logic [2:0] cmd_q;
  logic [1:0] phase_q;
  logic busy_q;
  logic done_q;
  logic pass_q;
  logic fail_q;
  logic avs_ack_q;
  logic start;
  logic [7:0] first_rd;

  // Unlock sequence address for each write step of a command
  function automatic logic [18:0] seq_addr(input logic [2:0] c,
                                           input logic [2:0] s,
                                           input logic [18:0] a);
    logic [18:0] r;
    r = FSW_UNLOCK_A1;
    if (c == FSW_CMD_WRITE) begin
      r = a;
    end else if (c == FSW_CMD_CHIP_ERASE) begin
      r = (s == 3'h1 || s == 3'h4) ? FSW_UNLOCK_A2 : FSW_UNLOCK_A1;
    end
    return r;
  endfunction

  // Data byte for each write step of a command
  function automatic logic [7:0] seq_data(input logic [2:0] c,
                                          input logic [2:0] s,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = d;
    if (c == FSW_CMD_RESET) begin
      r = FSW_RESET_CMD;
    end else if (c == FSW_CMD_CHIP_ERASE) begin
      case (s)
        3'h0: r = FSW_UNLOCK_D1;
        3'h1: r = FSW_UNLOCK_D2;
        3'h2: r = FSW_ERASE_SETUP;
        3'h3: r = FSW_UNLOCK_D1;
        3'h4: r = FSW_UNLOCK_D2;
        default: r = FSW_CHIP_ERASE;
      endcase
    end
    return r;
  endfunction

  // Number of write steps of a command, minus one
  function automatic logic [2:0] seq_last(input logic [2:0] c);
    logic [2:0] r;
    r = 3'h0;
    if (c == FSW_CMD_CHIP_ERASE) begin
      r = 3'h5;
    end
    return r;
  endfunction

  assign start = avs_write_in && !avs_ack_q && !busy_q &&
                 avs_address_in == FSW_REG_CTRL;
  assign first_rd = dq_sync_q;

  // Data bus input synchroniser
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dq_meta_q <= 8'h00;
      dq_sync_q <= 8'h00;
    end else begin
      dq_meta_q <= flash_dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // Avalon slave: one wait cycle, then acknowledge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_ack_q <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= FSW_ZERO_RST;
      addr_q <= 19'h00000;
      wdata_q <= 8'h00;
    end else begin
      avs_ack_q <= (avs_read_in || avs_write_in) && !avs_ack_q;
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !avs_ack_q);
      if (avs_write_in && !avs_ack_q) begin
        if (avs_address_in == FSW_REG_ADDR) begin
          addr_q <= avs_writedata_in[18:0];
        end
        if (avs_address_in == FSW_REG_DATA) begin
          wdata_q <= avs_writedata_in[7:0];
        end
      end
      if (avs_read_in && !avs_ack_q) begin
        case (avs_address_in)
          FSW_REG_ADDR: avs_readdata_out <= {13'h0000, addr_q};
          FSW_REG_DATA: avs_readdata_out <= {24'h000000, wdata_q};
          FSW_REG_STAT: avs_readdata_out <= {16'h0000, rdata_q, 4'h0,
                                             fail_q, pass_q, done_q, busy_q};
          default: avs_readdata_out <= FSW_ZERO_RST;
        endcase
      end
    end
  end

  // Bus sequencer and status polling
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= FSW_IDLE;
      cnt_q <= 4'h0;
      step_q <= 3'h0;
      cmd_q <= 3'h0;
      phase_q <= 2'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      rdata_q <= 8'h00;
      prev_q <= 8'h00;
      flash_addr_out <= 19'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
    end else begin
      case (state_q)
        FSW_IDLE: begin
          if (start) begin
            cmd_q <= avs_writedata_in[2:0];
            step_q <= 3'h0;
            phase_q <= 2'h0;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            state_q <= (avs_writedata_in[2:0] == FSW_CMD_READ ||
                        avs_writedata_in[2:0] == FSW_CMD_POLL) ?
                       FSW_R_SETUP : FSW_W_SETUP;
          end
        end
        FSW_W_SETUP: begin
          // Output strobe high before write strobe falls
          flash_oe_n_out <= 1'b1;
          flash_addr_out <= seq_addr(cmd_q, step_q, addr_q);
          flash_dq_out <= seq_data(cmd_q, step_q, wdata_q);
          flash_dq_oe_out <= 1'b1;
          flash_ce_n_out <= 1'b0;
          cnt_q <= FSW_WP_CNT;
          state_q <= FSW_W_PULSE;
        end
        FSW_W_PULSE: begin
          flash_we_n_out <= 1'b0;
          if (cnt_q == 4'h0) begin
            flash_we_n_out <= 1'b1;
            state_q <= FSW_W_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        FSW_W_HOLD: begin
          flash_ce_n_out <= 1'b1;
          flash_dq_oe_out <= 1'b0;
          if (step_q != seq_last(cmd_q)) begin
            step_q <= step_q + 3'h1;
            state_q <= FSW_W_SETUP;
          end else if (cmd_q == FSW_CMD_WRITE ||
                       cmd_q == FSW_CMD_CHIP_ERASE) begin
            state_q <= FSW_R_SETUP;
          end else begin
            // A reset sent after a failed erase must not report a pass
            busy_q <= 1'b0;
            done_q <= 1'b1;
            pass_q <= !fail_q;
            state_q <= FSW_IDLE;
          end
        end
        FSW_R_SETUP: begin
          // Each read is its own select cycle so the toggles advance
          flash_addr_out <= addr_q;
          flash_ce_n_out <= 1'b0;
          flash_oe_n_out <= 1'b0;
          cnt_q <= FSW_ACCESS_CNT + 4'h2;
          state_q <= FSW_R_WAIT;
        end
        FSW_R_WAIT: begin
          if (cnt_q == 4'h0) begin
            prev_q <= rdata_q;
            rdata_q <= first_rd;
            state_q <= FSW_R_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        FSW_R_HOLD: begin
          flash_ce_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          state_q <= (cmd_q == FSW_CMD_READ) ? FSW_IDLE : FSW_DECIDE;
          if (cmd_q == FSW_CMD_READ) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            pass_q <= 1'b1;
          end
        end
        FSW_DECIDE: begin
          // Phase 0 primes, 1 compares, 2 rechecks after timeout
          state_q <= FSW_R_SETUP;
          if (phase_q == 2'h0) begin
            phase_q <= 2'h1;
          end else if (rdata_q[FSW_MAIN_TOGGLE_FLAG] ==
                       prev_q[FSW_MAIN_TOGGLE_FLAG] &&
                       rdata_q[FSW_ERASE_REGION_TOGGLE] ==
                       prev_q[FSW_ERASE_REGION_TOGGLE]) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            pass_q <= 1'b1;
            state_q <= FSW_IDLE;
          end else if (phase_q == 2'h2) begin
            // Still toggling after timeout: failed, send reset
            fail_q <= 1'b1;
            cmd_q <= FSW_CMD_RESET;
            step_q <= 3'h0;
            state_q <= FSW_W_SETUP;
          end else if (rdata_q[FSW_TIMEOUT_FLAG]) begin
            phase_q <= 2'h2;
          end else begin
            phase_q <= 2'h1;
          end
        end
        default: begin
          state_q <= FSW_IDLE;
        end
      endcase
      if (state_q == FSW_W_HOLD && cmd_q == FSW_CMD_RESET &&
          fail_q) begin
        done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/fsw_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fsw_host_asserts (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [18:0] flash_addr_out,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Write strobe low for one cycle, then back high
  sequence we_pulse;
    !flash_we_n_out ##1 flash_we_n_out;
  endsequence
  // Read strobes held long enough for the access time
  sequence rd_hold;
    (!flash_oe_n_out && !flash_ce_n_out) [*3];
  endsequence
  chk_idle_reset: assert property ($rose(reset_n_in) |->
    flash_ce_n_out && flash_we_n_out && flash_oe_n_out)
    else $error("strobes not idle after reset");
  chk_write_gate: assert property (!flash_we_n_out |->
    !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe without select");
  chk_we_width: assert property ($fell(flash_we_n_out) |-> we_pulse)
    else $error("write pulse width wrong");
  chk_write_data: assert property (!flash_we_n_out |-> flash_dq_oe_out
    && $stable(flash_dq_out) && $stable(flash_addr_out))
    else $error("write data or address moved");
  chk_no_clash: assert property (!flash_oe_n_out |->
    !flash_dq_oe_out && flash_we_n_out)
    else $error("bus driven during read");
  chk_read_len: assert property ($fell(flash_oe_n_out) |-> rd_hold)
    else $error("read strobe too short");
  chk_ce_release: assert property ($rose(flash_ce_n_out) |->
    flash_we_n_out && flash_oe_n_out)
    else $error("select released under a strobe");
  chk_wait_answer: assert property ($rose(avs_read_in || avs_write_in)
    |=> !avs_waitrequest_out)
    else $error("no answer one cycle after request");
  chk_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h00000000)
    else $error("unmapped read not zero");
endmodule
bind fsw_host fsw_host_asserts u_chk (.clk_in, .reset_n_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
  .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_ce_n_out,
  .flash_we_n_out, .flash_oe_n_out);
`default_nettype wire

/* File: bench/fsw_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsw_flash_model
  import fsw_pkg::*;
#(
  parameter int BUSY_READS = 4,
  parameter logic [2:0] PROT_SECT = 3'h7
)
(
  input wire logic [18:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic fail_in,
  input wire logic vcc_ok_in,
  input wire logic susp_in,
  output logic [7:0] dq_out
);
  logic [7:0] seq_d [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h10};
  logic [7:0] mem [256];
  logic [7:0] rd_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic ers_q = 1'b0;
  logic prg_q = 1'b0;
  logic tmo_q = 1'b0;
  logic tog_q = 1'b0;
  logic rtog_q = 1'b0;
  int step = 0;
  int left = 0;
  int erases = 0;
  int resets = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Commands taken at write strobe rise, select low, output off
  always @(posedge we_n_in) begin
    if (!ce_n_in && oe_n_in) begin
      if (!vcc_ok_in) begin
        // Low supply: back to read mode, write dropped
        {ers_q, prg_q, tmo_q} = 3'b000;
        step = 0;
      end else if ((ers_q || prg_q) && !tmo_q) begin
        step = 0;
      end else if (dq_in == FSW_RESET_CMD) begin
        {ers_q, prg_q, tmo_q} = 3'b000;
        step = 0;
        resets++;
      end else if (dq_in == seq_d[step] && addr_in ==
          ((step == 1 || step == 4) ? FSW_UNLOCK_A2 : FSW_UNLOCK_A1)) begin
        step++;
        if (step == 6) begin
          foreach (mem[i]) mem[i] = 8'hFF;
          ers_q = 1'b1;
          left = BUSY_READS;
          step = 0;
          erases++;
        end
      end else if (step == 0) begin
        if (addr_in[18:16] != PROT_SECT) begin
          mem[addr_in[7:0]] = dq_in;
          last_q = dq_in;
          prg_q = 1'b1;
          left = BUSY_READS;
        end
      end else step = 0;
    end
  end
  // Status on each output strobe fall while busy, except suspended reads outside sector 0; array data otherwise
  always @(negedge oe_n_in) begin
    if (!ce_n_in && ers_q && susp_in) begin
      // Suspended: sector 0 shows status with main toggle frozen, region toggle flipping; others array data
      if (addr_in[18:16] == 3'h0) begin
        rtog_q = ~rtog_q;
        rd_q = {1'b1, tog_q, 1'b0, 1'b0, 1'b0, rtog_q, 2'h0};
      end else rd_q = mem[addr_in[7:0]];
    end else if (!ce_n_in && (ers_q || prg_q)) begin
      tog_q = ~tog_q;
      rd_q = {ers_q ? 1'b0 : ~last_q[7], tog_q, tmo_q, 1'b0, ers_q,
        ers_q & tog_q, 2'h0};
      if (left > 0) left--;
      else if (fail_in) tmo_q = 1'b1;
      else {ers_q, prg_q} = 2'b00;
    end else if (!ce_n_in) rd_q = mem[addr_in[7:0]];
  end
  // A released bus shows the inverse, never the stale byte
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_q : ~rd_q;
endmodule
`default_nettype wire

/* File: bench/fsw_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fsw_host_tb;
  import fsw_pkg::*;
  logic clk_in = 0, reset_n_in = 0, rd_s = 0, wr_s = 0, fail = 0;
  logic vcc = 1, susp = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic wait_r, dq_oe, ce_n, we_n, oe_n;
  logic [18:0] f_addr;
  logic [7:0] dq_h, dq_m, dq_bus;
  int mismatches = 0, tests_run = 0, cycles = 0;
  // Bus level from whichever side drives
  assign dq_bus = dq_oe ? dq_h : dq_m;
  initial forever #25 clk_in = ~clk_in;
  fsw_host u_dut (.clk_in, .reset_n_in, .avs_address_in(addr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
    .flash_addr_out(f_addr), .flash_dq_in(dq_bus), .flash_dq_out(dq_h),
    .flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n),
    .flash_we_n_out(we_n), .flash_oe_n_out(oe_n));
  fsw_flash_model u_mem (.addr_in(f_addr), .dq_in(dq_bus), .ce_n_in(ce_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .fail_in(fail), .vcc_ok_in(vcc),
    .susp_in(susp), .dq_out(dq_m));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= ~w;
    do @(posedge clk_in); while (wait_r !== 1'b0);
    rd = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk_in);
  endtask
  // Command, then poll status until busy clears
  task automatic run(input logic [2:0] c, input logic extra);
    acc(1'b1, FSW_REG_CTRL, {29'h0, c});
    if (extra) acc(1'b1, FSW_REG_CTRL, {29'h0, FSW_CMD_READ});
    do acc(1'b0, FSW_REG_STAT, 32'h0); while (rd[FSW_ST_BUSY] !== 1'b0);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    chk({28'h0, ce_n, we_n, oe_n, dq_oe}, 32'hE);
    acc(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    acc(1'b1, FSW_REG_ADDR, 32'h123);
    acc(1'b1, FSW_REG_DATA, 32'h5A);
    acc(1'b0, FSW_REG_ADDR, 32'h0);
    chk(rd, 32'h123);
    run(FSW_CMD_WRITE, 1'b0);
    run(FSW_CMD_POLL, 1'b0);
    chk({28'h0, rd[3:0]}, 32'h6);
    run(FSW_CMD_READ, 1'b0);
    chk({24'h0, rd[15:8]}, 32'h5A);
    run(FSW_CMD_CHIP_ERASE, 1'b1);
    chk({28'h0, rd[3:0]}, 32'h6);
    chk(u_mem.erases, 1);
    run(FSW_CMD_READ, 1'b0);
    chk({24'h0, rd[15:8]}, 32'hFF);
    acc(1'b1, FSW_REG_ADDR, 32'h70024);
    acc(1'b1, FSW_REG_DATA, 32'h33);
    run(FSW_CMD_WRITE, 1'b0);
    run(FSW_CMD_READ, 1'b0);
    chk({24'h0, rd[15:8]}, 32'hFF);
    vcc <= 1'b0;
    acc(1'b1, FSW_REG_ADDR, 32'h25);
    run(FSW_CMD_WRITE, 1'b0);
    vcc <= 1'b1;
    run(FSW_CMD_READ, 1'b0);
    chk({24'h0, rd[15:8]}, 32'hFF);
    susp <= 1'b1;
    acc(1'b1, FSW_REG_ADDR, 32'h10000);
    run(FSW_CMD_CHIP_ERASE, 1'b0);
    chk({28'h0, rd[3:0]}, 32'h6);
    acc(1'b1, FSW_REG_ADDR, 32'h0);
    run(FSW_CMD_READ, 1'b0);
    chk({24'h0, rd[15:8] & 8'hA0}, 32'h80);
    susp <= 1'b0;
    run(FSW_CMD_POLL, 1'b0);
    chk({28'h0, rd[3:0]}, 32'h6);
    chk(u_mem.erases, 2);
    fail <= 1'b1;
    run(FSW_CMD_CHIP_ERASE, 1'b0);
    chk({28'h0, rd[3:0]}, 32'hA);
    chk(u_mem.resets, 1);
    fail <= 1'b0;
    run(FSW_CMD_RESET, 1'b0);
    chk(u_mem.resets, 2);
    end_sim();
  end
endmodule
`default_nettype wire
